/* File: verilog/dds_core.sv */
// Direct digital synthesis core with output path selection and AXI4-Lite registers.
// Operation
// R01: Waveform memory holds one cycle as 1024 ten-bit samples.
// R02: Each address step is one 1024th of a full cycle.
// R03: Every clock the loaded increment is added to the accumulator.
// R04: Only the top ten accumulator bits address the memory.
// R05: Accumulator is 38 bits at about 27.487 MHz, 0.1 mHz steps.
// R06: Changing the increment keeps the accumulator, so phase stays continuous.
// R07: Addressed samples go to the converter one per clock.
// R08: Output frequency is limited to 10 MHz.
// R09: Automatic mode uses low-frequency generation up to 30 kHz, else high.
// R10: Forced low or high generation applies at every frequency.
// R11: Filter automatic depends on waveform; forced on filters all, off none.
// R12: Automatic filter passes sine and triangle through the filter.
// R13: Automatic filter bypasses ramp, stair, arbitrary and asymmetric waveforms.
// R14: High-frequency square and pulse come from comparator fed by filtered sine.
// R15: Aux comparator uses filtered sine for high-frequency square, else main waveform.
// R16: Automatic aux is low-frequency for ramp, stair, arb, low-frequency square/pulse.
// R17: Aux phase shift applies only while aux uses low-frequency generation.
// R18: Sweep or FSK freezes automatic modes; forced selections still win.
// R19: Symmetry S maps first half-cycle into S percent, rest into remainder.
// R20: Burst phase compares true accumulator phase, not symmetry-scaled.
// R21: Accumulator wraps modulo two to the 38, no saturation or clear.
// R22: A new increment takes effect in one clock as a whole value.
module dds_core
	import dds_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	// AXI4-Lite write address and data.
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic [1:0]                s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [7:0]           s_axi_araddr,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	// Converter samples and analog path control.
	output logic [dds_pkg::SAMP_W-1:0] dac_data,
	output logic [dds_pkg::SAMP_W-1:0] aux_data,
	output dds_pkg::dds_path_t         path,
	output logic                       burst_phase_hit
);
	import dds_pkg::*;

	// Configuration state.
	dds_wave_t             wave;
	dds_mode_t             square_pulse_generation_mode;
	dds_mode_t             aux_mode;
	dds_filt_t             filt_mode;
	logic                  sweep_fsk;
	logic [31:0]           inc_lo_shadow;
	logic [ACC_W-1:0]      inc_live;
	logic [6:0]            symm;
	logic [ADDR_W-1:0]     aux_phase;
	logic [ADDR_W-1:0]     burst_phase;
	logic [ADDR_W-1:0]     mem_ptr;
	logic [SAMP_W-1:0]     mem [MEM_LEN];
	logic [ACC_W-1:0]      acc;
	logic                  frozen_hf;
	logic                  sweep_d;

	// Bus handshake state.
	logic                  aw_got;
	logic                  w_got;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  wr_do;
	logic                  wr_ok;
	logic [ACC_W-1:0]      next_inc;

	// Write side: address and data are captured independently in any order.
	assign s_axi_awready = ce && !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_got && !s_axi_bvalid;
	assign wr_do         = ce && aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable offsets; the status word and anything else answer with an error.
	always_comb
	begin
		case (aw_addr)
			REG_CTRL, REG_INC_LO, REG_INC_HI, REG_SYMM,
			REG_AUXPH, REG_BURSTP, REG_MADDR, REG_MDATA: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// The full increment is assembled from the low shadow and the high write, then clamped.
	always_comb
	begin
		next_inc = {w_data[ACC_W-33:0], inc_lo_shadow};
		if (next_inc > INC_MAX)
		begin
			next_inc = INC_MAX; // see R08
		end
	end

	// Configuration registers; byte enables gate only the control fields; aux and filter modes both need lanes 0 and 1.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wave                         <= wave_sine;
			square_pulse_generation_mode <= mode_auto;
			aux_mode                     <= mode_auto;
			filt_mode                    <= filt_auto;
			sweep_fsk                    <= 1'b0;
			inc_lo_shadow                <= 32'h0;
			inc_live                     <= INC_RST;
			symm                         <= SYMM_RST;
			aux_phase                    <= 10'h000;
			burst_phase                  <= 10'h000;
		end
		else if (ce && wr_do)
		begin
			case (aw_addr)
				REG_CTRL:
				begin
					if (w_strb[0])
					begin
						wave <= dds_wave_t'(w_data[CTRL_WAVE +: 3]);
						square_pulse_generation_mode <= dds_mode_t'(w_data[CTRL_SQ +: 2]);
					end
					if (w_strb[0] && w_strb[1])
					begin
						aux_mode  <= dds_mode_t'(w_data[CTRL_AUX +: 2]);
						filt_mode <= dds_filt_t'(w_data[CTRL_FILT +: 2]);
					end
					if (w_strb[1])
					begin
						sweep_fsk <= w_data[CTRL_SWEEP];
					end
				end
				REG_INC_LO: inc_lo_shadow <= w_data;
				// Whole value replaces the live one at once; the accumulator is untouched.
				REG_INC_HI: inc_live <= next_inc; // see R22 see R06
				REG_SYMM:
				begin
					if (w_data[6:0] < SYMM_MIN)
					begin
						symm <= SYMM_MIN;
					end
					else if (w_data[6:0] > SYMM_MAX || w_data[31:7] != 25'h0)
					begin
						symm <= SYMM_MAX;
					end
					else
					begin
						symm <= w_data[6:0];
					end
				end
				REG_AUXPH:  aux_phase <= w_data[ADDR_W-1:0];
				REG_BURSTP: burst_phase <= w_data[ADDR_W-1:0];
				default:    symm <= symm;
			endcase
		end
	end

	// Memory loader: a pointer that steps after each data write, so a table loads in one burst.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mem_ptr <= 10'h000;
		end
		else if (ce && wr_do)
		begin
			if (aw_addr == REG_MADDR)
			begin
				mem_ptr <= w_data[ADDR_W-1:0];
			end
			else if (aw_addr == REG_MDATA)
			begin
				mem_ptr <= mem_ptr + 10'h001;
			end
		end
	end

	// Waveform storage; left without reset since software always loads it.
	always_ff @(posedge aclk)
	begin
		if (ce && wr_do && aw_addr == REG_MDATA)
		begin
			mem[mem_ptr] <= w_data[SAMP_W-1:0]; // see R01
		end
	end

	// Phase accumulator; plain addition wraps at two to the 38.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc <= 38'h0;
		end
		else if (ce)
		begin
			acc <= acc + inc_live; // see R03 see R05 see R21
		end
	end

	// Phase index, symmetry breakpoint and scaled addresses.
	logic [ADDR_W-1:0] phase_idx;
	logic [ADDR_W-1:0] aux_idx;
	logic [ADDR_W-1:0] brk;
	logic [ADDR_W-1:0] main_addr;
	logic [ADDR_W-1:0] aux_addr;

	assign phase_idx = acc[ACC_W-1 -: ADDR_W]; // see R04 see R02
	assign brk = 10'((17'(symm) * 17'd1024) / 17'd100);

	// Maps the first half-cycle onto the phases below the breakpoint and the rest onto the phases after it.
	function automatic logic [ADDR_W-1:0] symm_map(input logic [ADDR_W-1:0] p,
		input logic [ADDR_W-1:0] b);
		logic [19:0] num;
		logic [10:0] den;
		num = 20'h0;
		den = 11'h0;
		if (p < b)
		begin
			num = {1'b0, p, 9'h000};
			symm_map = 10'(num / 20'(b));
		end
		else
		begin
			num = {1'b0, 10'(p - b), 9'h000};
			den = 11'd1024 - 11'(b);
			symm_map = 10'(10'h200 + 10'(num / 20'(den)));
		end
	endfunction

	// The aux offset only counts while aux runs in low-frequency generation.
	assign aux_idx   = path.aux_hf ? phase_idx : 10'(phase_idx + aux_phase); // see R17
	assign main_addr = symm_map(phase_idx, brk); // see R19
	assign aux_addr  = symm_map(aux_idx, brk);

	// Converter samples; one registered read per clock in accumulator order.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dac_data <= 10'h000;
			aux_data <= 10'h000;
		end
		else if (ce)
		begin
			dac_data <= mem[main_addr]; // see R07
			aux_data <= mem[aux_addr];
		end
	end

	// Burst phase works on the unscaled accumulator phase.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			burst_phase_hit <= 1'b0;
		end
		else if (ce)
		begin
			burst_phase_hit <= (phase_idx == burst_phase); // see R20
		end
	end

	// Automatic frequency decision and its freeze at the start of sweep or FSK.
	logic auto_hf;
	logic eff_auto_hf;
	assign auto_hf     = inc_live > LF_LIMIT; // see R09
	assign eff_auto_hf = sweep_fsk ? frozen_hf : auto_hf; // see R18

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frozen_hf <= 1'b0;
			sweep_d   <= 1'b0;
		end
		else if (ce)
		begin
			sweep_d <= sweep_fsk;
			if (!sweep_fsk)
			begin
				frozen_hf <= auto_hf; // see R18
			end
		end
	end

	// Path decisions; forced modes always beat the automatic choice.
	dds_path_t next_path;
	logic      wave_sq;
	logic      wave_shaped;

	always_comb
	begin
		wave_sq     = (wave == wave_square) || (wave == wave_pulse);
		wave_shaped = (wave == wave_ramp) || (wave == wave_stair) || (wave == wave_arb);
		case (square_pulse_generation_mode)
			low_freq_generation:  next_path.main_hf = 1'b0; // see R10
			high_freq_generation: next_path.main_hf = 1'b1;
			default:              next_path.main_hf = eff_auto_hf;
		endcase
		case (aux_mode)
			low_freq_generation:  next_path.aux_hf = 1'b0; // see R10
			high_freq_generation: next_path.aux_hf = 1'b1;
			default:
				next_path.aux_hf = eff_auto_hf && !wave_shaped
					&& !(wave_sq && !next_path.main_hf); // see R16
		endcase
		case (filt_mode)
			filt_on:  next_path.filter_en = 1'b1; // see R11
			filt_off: next_path.filter_en = 1'b0;
			default:
				next_path.filter_en = ((wave == wave_sine) || (wave == wave_tri))
					&& (symm == SYMM_RST); // see R12 see R13
		endcase
		next_path.main_cmp_sine = wave_sq && next_path.main_hf; // see R14
		next_path.aux_cmp_sine  = wave_sq && next_path.main_hf; // see R15
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			path <= '0;
		end
		else if (ce)
		begin
			path <= next_path;
		end
	end

	// Read side: one read at a time, data captured on the address handshake.
	assign s_axi_arready = ce && !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OK;
				case (s_axi_araddr)
					REG_CTRL:   s_axi_rdata <= {22'h0, sweep_fsk, filt_mode, aux_mode,
						square_pulse_generation_mode, wave};
					REG_INC_LO: s_axi_rdata <= inc_live[31:0];
					REG_INC_HI: s_axi_rdata <= {26'h0, inc_live[ACC_W-1:32]};
					REG_SYMM:   s_axi_rdata <= {25'h0, symm};
					REG_AUXPH:  s_axi_rdata <= {22'h0, aux_phase};
					REG_BURSTP: s_axi_rdata <= {22'h0, burst_phase};
					REG_MADDR:  s_axi_rdata <= {22'h0, mem_ptr};
					REG_MDATA:  s_axi_rdata <= {22'h0, mem[mem_ptr]};
					REG_STATUS: s_axi_rdata <= {6'h0, phase_idx, 11'h0, path};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_ERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks next to the logic they guard.
	inc_limit_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R08
		inc_live <= INC_MAX) else $error("Live increment above the 10 MHz limit.");

	acc_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R03
		ce |=> acc == 38'($past(acc) + $past(inc_live)))
		else $error("Accumulator did not add the increment.");

	acc_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R06
		(wr_do && aw_addr == REG_INC_HI) |=> acc == 38'($past(acc) + $past(inc_live)))
		else $error("Accumulator disturbed by increment change.");

	inc_commit_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R22
		(ce && wr_do && aw_addr == REG_INC_HI) |=> inc_live == $past(next_inc))
		else $error("Increment not committed whole in one clock.");

	filt_force_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
		(filt_mode == filt_on) |-> next_path.filter_en)
		else $error("Forced filter not applied.");

	filt_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R13
		(filt_mode == filt_auto && (wave == wave_ramp || symm != SYMM_RST))
		|-> !next_path.filter_en) else $error("Filter not bypassed.");

	force_lf_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
		(square_pulse_generation_mode == low_freq_generation) |-> !next_path.main_hf)
		else $error("Forced low-frequency generation ignored.");

	sweep_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R18
		(ce && sweep_fsk && sweep_d && $stable(square_pulse_generation_mode)
		&& square_pulse_generation_mode == mode_auto) |-> $stable(next_path.main_hf))
		else $error("Generation mode changed during sweep.");

	burst_true_a: assert property (@(posedge aclk) disable iff (!aresetn) // see R20
		ce |=> burst_phase_hit == ($past(phase_idx) == $past(burst_phase)))
		else $error("Burst phase not taken from true phase.");

endmodule // dds_core

/* File: verilog/dds_pkg.sv */
// Constants, register map and carrier types of the waveform synthesis core.
package dds_pkg;

	// Accumulator and waveform memory geometry.
	localparam int ACC_W   = 38;
	localparam int ADDR_W  = 10;
	localparam int SAMP_W  = 10;
	localparam int MEM_LEN = 1024;

	// Frequency figures; one increment unit is 0.1 mHz, so 10000 units per hertz.
	localparam longint UNITS_PER_HZ = 10000;
	localparam longint MAX_OUT_HZ   = 10000000;
	localparam longint LF_LIMIT_HZ  = 30000;
	localparam logic [37:0] INC_MAX  = 38'(MAX_OUT_HZ * UNITS_PER_HZ);
	localparam logic [37:0] LF_LIMIT = 38'(LF_LIMIT_HZ * UNITS_PER_HZ);

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_INC_LO = 8'h04;
	localparam logic [7:0] REG_INC_HI = 8'h08;
	localparam logic [7:0] REG_SYMM   = 8'h0c;
	localparam logic [7:0] REG_AUXPH  = 8'h10;
	localparam logic [7:0] REG_BURSTP = 8'h14;
	localparam logic [7:0] REG_MADDR  = 8'h18;
	localparam logic [7:0] REG_MDATA  = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;

	// Control field positions.
	localparam int CTRL_WAVE  = 0;
	localparam int CTRL_SQ    = 3;
	localparam int CTRL_AUX   = 5;
	localparam int CTRL_FILT  = 7;
	localparam int CTRL_SWEEP = 9;

	// Values after reset and symmetry limits.
	localparam logic [6:0]  SYMM_RST = 7'h32;
	localparam logic [6:0]  SYMM_MIN = 7'h01;
	localparam logic [6:0]  SYMM_MAX = 7'h63;
	localparam logic [37:0] INC_RST  = 38'h0;

	// AXI response codes.
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		wave_sine  = 3'h0, wave_tri  = 3'h1, wave_square = 3'h2, wave_pulse = 3'h3,
		wave_ramp  = 3'h4, wave_stair = 3'h5, wave_arb = 3'h6
	} dds_wave_t;

	typedef enum logic [1:0] {
		mode_auto = 2'h0, low_freq_generation = 2'h1, high_freq_generation = 2'h2
	} dds_mode_t;

	typedef enum logic [1:0] {
		filt_auto = 2'h0, filt_on = 2'h1, filt_off = 2'h2
	} dds_filt_t;

	// Output path selection handed to the analog side.
	typedef struct packed {
		logic main_hf;
		logic aux_hf;
		logic filter_en;
		logic aux_cmp_sine;
		logic main_cmp_sine;
	} dds_path_t;

endpackage : dds_pkg

/* File: verif/dds_dac_model.sv */
// Behavioural model of the converter and analog output path beside the core.
module dds_dac_model
	import dds_pkg::*;
(
	// Clock.
	input  wire logic                       aclk,
	// Samples and path control from the core.
	input  wire logic [dds_pkg::SAMP_W-1:0] dac_data,
	input  wire logic [dds_pkg::SAMP_W-1:0] aux_data,
	input  wire dds_pkg::dds_path_t         path,
	// What the analog side made of them.
	output logic      [dds_pkg::SAMP_W-1:0] dac_seen,
	output logic                            cmp_from_sine
);
	import dds_pkg::*;

	// The converter latches one sample per clock, so the bench sees the stream one cycle late.
	always_ff @(posedge aclk)
		dac_seen <= dac_data;

	// The comparator takes the filtered sine only for high frequency square and pulse.
	assign cmp_from_sine = path.main_cmp_sine;
endmodule // dds_dac_model

/* File: verif/tb_top.sv */
// Self-checking bench of the waveform synthesis core with its analog path model.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dds_pkg::*;

	logic              aclk = 1'b0, aresetn = 1'b0, ce = 1'b0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic [31:0]       s_axi_rdata, d;
	logic [SAMP_W-1:0] dac_data, aux_data, dac_seen;
	dds_path_t         path;
	logic              burst_phase_hit, cmp_from_sine;
	int                mismatches = 0, n_tests = 0;
	localparam logic [37:0] HI_INC = LF_LIMIT + 38'h1;

	dds_core dds_core_i (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dac_data, .aux_data, .path, .burst_phase_hit);
	dds_dac_model dds_dac_model_i (.aclk, .dac_data, .aux_data, .path, .dac_seen, .cmp_from_sine);

	// Free running 100 MHz clock.
	always #5 aclk = ~aclk;

	// Prints the verdict and stops the run.
	task automatic end_sim();
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %0h seen %0h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Write; handshakes are judged at the falling edge since inputs only move on rising edges.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ha, hw, hb;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_bready <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready === 1'b1;
			hw = s_axi_wvalid && s_axi_wready === 1'b1;
			hb = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	// Read; data and response are taken at the edge where rvalid is seen.
	task automatic rd(input logic [7:0] a);
		logic ha, hr;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready === 1'b1;
			hr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ha)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic setinc(input logic [37:0] v);
		wr(REG_INC_LO, v[31:0]);
		wr(REG_INC_HI, {26'h0, v[37:32]});
	endtask

	task automatic ctl(input logic [2:0] wv, input logic [1:0] sq, au, fl, input logic sw);
		wr(REG_CTRL, (32'(wv) << CTRL_WAVE) | (32'(sq) << CTRL_SQ) | (32'(au) << CTRL_AUX)
			| (32'(fl) << CTRL_FILT) | (32'(sw) << CTRL_SWEEP));
	endtask

	// Reset value, refused accesses and the increment ceiling.
	task automatic t_regs();
		rd(REG_SYMM);
		chk("symm", d, SYMM_RST);
		rd(8'h24);
		chk("rresp", r, RESP_ERR);
		chk("rdata", d, 0);
		wr(8'h24, 32'h1);
		chk("bresp", r, RESP_ERR);
		wr(REG_STATUS, 32'h1);
		chk("bresp", r, RESP_ERR);
		setinc(38'h3f_ffff_ffff);
		rd(REG_INC_LO);
		chk("inc_lo", d, INC_MAX[31:0]);
		rd(REG_INC_HI);
		chk("inc_hi", d, INC_MAX[37:32]);
		setinc(38'h0);
	endtask

	// Loads every entry with its own index so a sample names its address.
	task automatic t_load();
		wr(REG_MADDR, 32'h0);
		for (int i = 0; i < MEM_LEN; i++)
			wr(REG_MDATA, 32'(i));
	endtask

	// One address per clock across a wrap, a freeze, then a glide to sixteen per clock.
	task automatic t_stream();
		logic [9:0] p;
		setinc(38'h10000000);
		cyc(3);
		@(negedge aclk);
		p = dac_seen;
		repeat (1100)
		begin
			@(negedge aclk);
			chk("step", 10'(dac_seen - p), 1);
			p = dac_seen;
		end
		@(posedge aclk);
		ce <= 1'b0;
		cyc(2);
		@(negedge aclk);
		p = dac_data;
		cyc(4);
		@(negedge aclk);
		chk("frozen_ce", dac_data, p);
		@(posedge aclk);
		ce <= 1'b1;
		cyc(3);
		@(negedge aclk);
		p = dac_seen;
		// A partial update would show a zero step between the two halves.
		fork
			setinc(38'h1_0000_0000);
			repeat (40)
			begin
				@(negedge aclk);
				chk("glide", 10'(dac_seen - p) inside {10'd1, 10'd16}, 1);
				p = dac_seen;
			end
		join
		@(negedge aclk);
		chk("step16", 10'(dac_seen - p), 16);
	endtask

	// Symmetry mapping, burst phase and auxiliary phase at a standing accumulator.
	task automatic t_symm();
		logic [9:0] p;
		int b, e;
		setinc(38'h0);
		wr(REG_SYMM, 32'd25);
		rd(REG_STATUS);
		p = d[25:16];
		cyc(3);
		b = 25 * 1024 / 100;
		e = (p < b) ? p * 512 / b : 512 + (p - b) * 512 / (1024 - b);
		@(negedge aclk);
		chk("symm_map", dac_data, e[9:0]);
		chk("filter", path.filter_en, 0);
		wr(REG_BURSTP, {22'h0, p});
		cyc(3);
		@(negedge aclk);
		chk("burst", burst_phase_hit, 1);
		wr(REG_BURSTP, 32'(e));
		cyc(3);
		@(negedge aclk);
		chk("burst", burst_phase_hit, 10'(e) == p);
		wr(REG_SYMM, 32'd50);
		wr(REG_AUXPH, 32'd5);
		ctl(wave_sine, mode_auto, high_freq_generation, filt_auto, 1'b0);
		cyc(3);
		@(negedge aclk);
		chk("aux_hf", aux_data, p);
		ctl(wave_sine, mode_auto, low_freq_generation, filt_auto, 1'b0);
		cyc(3);
		@(negedge aclk);
		chk("aux_lf", aux_data, 10'(p + 10'h005));
	endtask

	// One configuration and the path bits it must give under a mask.
	task automatic row(input logic [2:0] wv, input logic [1:0] sq, au, fl,
		input logic [37:0] inc, input logic [4:0] e, input logic [4:0] m);
		ctl(wv, sq, au, fl, 1'b0);
		setinc(inc);
		cyc(3);
		@(negedge aclk);
		chk("path", path & m, e & m);
		chk("cmp_from_sine", cmp_from_sine, e[0]);
	endtask

	task automatic t_modes();
		row(wave_square, mode_auto, mode_auto, filt_auto, LF_LIMIT, 5'h00, 5'h1f);
		row(wave_square, mode_auto, mode_auto, filt_auto, HI_INC, 5'h1b, 5'h1f);
		row(wave_square, low_freq_generation, mode_auto, filt_auto, HI_INC, 5'h00, 5'h1f);
		row(wave_pulse, high_freq_generation, mode_auto, filt_auto, 0, 5'h13, 5'h1f);
		row(wave_sine, mode_auto, mode_auto, filt_auto, HI_INC, 5'h0c, 5'h0f);
		row(wave_ramp, mode_auto, mode_auto, filt_auto, HI_INC, 5'h00, 5'h0f);
		row(wave_tri, mode_auto, mode_auto, filt_auto, 0, 5'h04, 5'h04);
		row(wave_stair, mode_auto, mode_auto, filt_on, HI_INC, 5'h04, 5'h0c);
		row(wave_sine, mode_auto, mode_auto, filt_off, 0, 5'h00, 5'h04);
		row(wave_arb, mode_auto, high_freq_generation, filt_auto, HI_INC, 5'h08, 5'h0c);
		row(wave_square, mode_auto, mode_auto, filt_auto, 0, 5'h00, 5'h10);
		ctl(wave_square, mode_auto, mode_auto, filt_auto, 1'b1);
		setinc(HI_INC);
		cyc(3);
		@(negedge aclk);
		chk("frozen", path.main_hf, 0);
		ctl(wave_square, high_freq_generation, mode_auto, filt_auto, 1'b1);
		cyc(3);
		@(negedge aclk);
		chk("forced", path.main_hf, 1);
	endtask

	// Main sequence after twenty cycles of reset.
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		ce <= 1'b1;
		t_regs();
		t_load();
		t_stream();
		t_symm();
		t_modes();
		end_sim();
	end

	// Watchdog well beyond the roughly six thousand cycles the run needs.
	initial
	begin
		#400000;
		mismatches++;
		end_sim();
	end
endmodule // tb_top
